// ===== rtl/otpc_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by its bare name from the controller package users
`ifndef OTPC_MAP_SVH
`define OTPC_MAP_SVH

// ----------------------------------------------------------------------
// Register word indices (printed offsets are indices, byte addr = 4*idx)
// ----------------------------------------------------------------------
`define OTPC_IDX_PGM_CTRL   16'h3D80
`define OTPC_IDX_LOAD_CTRL  16'h3D81
`define OTPC_IDX_PGM_PULSE  16'h3D82
`define OTPC_IDX_LOAD_PULSE 16'h3D83
`define OTPC_IDX_MODE       16'h3D84
`define OTPC_IDX_EXTRA      16'h3D85
`define OTPC_IDX_BUF_TEST   16'h3D86
`define OTPC_IDX_TIMING_A   16'h3D87
`define OTPC_IDX_MSTART_H   16'h3D88
`define OTPC_IDX_MSTART_L   16'h3D89
`define OTPC_IDX_MEND_H     16'h3D8A
`define OTPC_IDX_MEND_L     16'h3D8B
`define OTPC_IDX_SSTART_H   16'h3D8C
`define OTPC_IDX_SSTART_L   16'h3D8D
`define OTPC_IDX_FAIL_H     16'h3D8E
`define OTPC_IDX_FAIL_L     16'h3D8F
`define OTPC_IDX_PGM_GAP    16'h3D90
`define OTPC_IDX_LOAD_GAP   16'h3D91
`define OTPC_IDX_TIMING_B   16'h3D92
`define OTPC_IDX_BUF_BASE   16'h6000
`define OTPC_IDX_BUF_LAST   16'h7FFF

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OTPC_BIT_BUSY       7
`define OTPC_BIT_TRIG       0
`define OTPC_BIT_BIST_ERR   5
`define OTPC_BIT_BIST_DONE  4
`define OTPC_BIT_PGM_DIS    7
`define OTPC_BIT_MANUAL     6
`define OTPC_BIT_BIST_ZERO  5
`define OTPC_BIT_BIST_EN    4
`define OTPC_BIT_PU_DATA    2
`define OTPC_BIT_PU_SET     1
`define OTPC_BIT_WR_SET     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OTPC_RST_PGM_PULSE  8'h2E
`define OTPC_RST_LOAD_PULSE 8'h12
`define OTPC_RST_MODE       8'h80
`define OTPC_RST_EXTRA      8'h13
`define OTPC_RST_BUF_TEST   8'h01
`define OTPC_RST_TIMING_A   8'h6C
`define OTPC_RST_PGM_GAP    8'h18
`define OTPC_RST_LOAD_GAP   8'h06
`define OTPC_RST_TIMING_B   8'h2A

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define OTPC_PULSE_STEP     8
`define OTPC_GAP_STEP       8

`endif

// ===== rtl/otpc_pkg.sv
// Types shared by the controller and its byte buffer
// Assumes the constant header is on the include path
package otpc_pkg;

  typedef enum logic [2:0] {
    OTPC_IDLE,
    OTPC_SETUP,
    OTPC_STROBE,
    OTPC_GAP,
    OTPC_FINISH
  } otpc_state_type;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [15:0] index;
  } otpc_req_type;

  typedef struct packed {
    logic        pgm_dis;
    logic        manual;
    logic        bist_zero;
    logic        bist_en;
    logic        pu_data;
    logic        pu_set;
    logic        wr_set;
  } otpc_cfg_type;

  typedef struct packed {
    logic        power_select;
    logic        chip_select_low;
    logic        program_gate_start;
    logic        program_gate_end_low;
    logic        strobe;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } otpc_macro_type;

endpackage

// ===== rtl/otpc_buffer.sv
// Byte buffer between the bus and the one-time memory macro
// Assumes one clock; port A serves the bus, port B the sequencer
`timescale 1ns/100ps
module otpc_buffer
  import otpc_pkg::*;
#(
  parameter int ADDR_W = 13,
  parameter int DEPTH  = 8192
) (
  input  wire logic              hclk,     // System clock
  input  wire logic              a_we,     // Bus write strobe
  input  wire logic [ADDR_W-1:0] a_addr,   // Bus byte address
  input  wire logic [7:0]        a_wdata,  // Bus write byte
  output logic      [7:0]        a_rdata,  // Bus read byte, registered
  input  wire logic              b_we,     // Sequencer write strobe
  input  wire logic [ADDR_W-1:0] b_addr,   // Sequencer byte address
  input  wire logic [7:0]        b_wdata,  // Sequencer write byte
  output logic      [7:0]        b_rdata   // Sequencer read byte
);

  logic [7:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << ADDR_W) || DEPTH < 2)
      $error("otpc_buffer: DEPTH does not fit ADDR_W");
  end

  // Bus port wins when both write the same byte in one cycle
  always_ff @(posedge hclk) begin
    if (b_we)
      mem[b_addr] <= b_wdata;
    if (a_we)
      mem[a_addr] <= a_wdata;
  end

  always_ff @(posedge hclk) begin
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule

// ===== rtl/otpc_bus.sv
// AHB-Lite slave front end: one pending write or read per transfer
// Assumes single word transfers; every answer is OKAY
`timescale 1ns/100ps
module otpc_bus
  import otpc_pkg::*;
(
  input  wire logic        hclk,       // System clock
  input  wire logic        hresetn,    // Async reset, active low
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic        hready,     // Bus ready
  output otpc_req_type     req,        // Registered data-phase request
  output logic             dphase      // Data phase in progress
);

  // ----------------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req    <= '0;
      dphase <= 1'b0;
    end else if (hready) begin
      dphase    <= hsel && htrans[1];
      req.sel   <= hsel && htrans[1];
      req.write <= hwrite;
      req.index <= haddr[17:2];
    end
  end

endmodule

// ===== rtl/otpc_top.sv
// One-time memory controller: registers, byte buffer, strobe sequencer
// Assumes an AHB-Lite master and an external memory macro on the pins
`timescale 1ns/100ps
`include "otpc_map.svh"

module otpc_top
  import otpc_pkg::*;
#(
  parameter logic [15:0] AUTO_FIRST = 16'h7000,
  parameter logic [15:0] AUTO_LAST  = 16'h79FF,
  parameter int          BUF_AW     = 13
) (
  input  wire logic        hclk,       // System clock, 40 MHz
  input  wire logic        hresetn,    // Async reset, active low
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic [2:0]  hsize,      // Transfer size
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic        hready,     // Bus ready
  output logic [31:0]      hrdata,     // Read data
  output logic             hreadyout,  // Slave ready
  output logic             hresp,      // Always OKAY
  output otpc_macro_type   macro,      // Memory macro controls
  input  wire logic [7:0]  macro_rdata, // Macro read byte
  output logic             setting_valid, // Setting byte strobe
  output logic [7:0]       setting_data   // Setting byte from memory
);

  initial begin
    if (BUF_AW != 13)
      $error("otpc_top: buffer window needs 13 address bits");
  end

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------
  otpc_req_type req;
  logic         dphase;
  logic         wr_en;
  logic         rd_wait;
  logic         rd_late;
  logic [7:0]   wbyte;
  logic         is_buf;

  otpc_bus u_bus (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hready  (hready),
    .req     (req),
    .dphase  (dphase)
  );

  assign wbyte  = hwdata[7:0];
  assign wr_en  = dphase && req.sel && req.write;
  assign is_buf = req.index >= `OTPC_IDX_BUF_BASE;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [7:0]  pgm_pulse, load_pulse, mode, extra, buf_test;
  logic [7:0]  timing_a, timing_b, pgm_gap, load_gap;
  logic [15:0] mstart, mend, sstart, fail_addr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pgm_pulse  <= `OTPC_RST_PGM_PULSE;
      load_pulse <= `OTPC_RST_LOAD_PULSE;
      mode       <= `OTPC_RST_MODE;
      extra      <= `OTPC_RST_EXTRA;
      buf_test   <= `OTPC_RST_BUF_TEST;
      timing_a   <= `OTPC_RST_TIMING_A;
      timing_b   <= `OTPC_RST_TIMING_B;
      pgm_gap    <= `OTPC_RST_PGM_GAP;
      load_gap   <= `OTPC_RST_LOAD_GAP;
      mstart     <= 16'h0000;
      mend       <= 16'h0000;
      sstart     <= 16'h0000;
    end else if (wr_en) begin
      case (req.index)
        `OTPC_IDX_PGM_PULSE:  pgm_pulse  <= wbyte;
        `OTPC_IDX_LOAD_PULSE: load_pulse <= wbyte;
        `OTPC_IDX_MODE:       mode       <= wbyte & 8'hC0;
        `OTPC_IDX_EXTRA:      extra      <= wbyte & 8'h37;
        `OTPC_IDX_BUF_TEST:   buf_test   <= wbyte & 8'h7F;
        `OTPC_IDX_TIMING_A:   timing_a   <= wbyte;
        `OTPC_IDX_TIMING_B:   timing_b   <= wbyte;
        `OTPC_IDX_PGM_GAP:    pgm_gap    <= wbyte;
        `OTPC_IDX_LOAD_GAP:   load_gap   <= wbyte;
        `OTPC_IDX_MSTART_H:   mstart[15:8] <= wbyte;
        `OTPC_IDX_MSTART_L:   mstart[7:0]  <= wbyte;
        `OTPC_IDX_MEND_H:     mend[15:8]   <= wbyte;
        `OTPC_IDX_MEND_L:     mend[7:0]    <= wbyte;
        `OTPC_IDX_SSTART_H:   sstart[15:8] <= wbyte;
        `OTPC_IDX_SSTART_L:   sstart[7:0]  <= wbyte;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Trigger decode
  // ----------------------------------------------------------------------
  logic pgm_trig, load_trig;
  logic busy_w, busy_r, bist_done, bist_err;
  logic pu_pending;

  assign pgm_trig  = wr_en && req.index == `OTPC_IDX_PGM_CTRL
                     && wbyte[`OTPC_BIT_TRIG]
                     && !mode[`OTPC_BIT_PGM_DIS];
  assign load_trig = wr_en && req.index == `OTPC_IDX_LOAD_CTRL
                     && wbyte[`OTPC_BIT_TRIG];

  // ----------------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------------
  otpc_state_type state;
  logic        op_pgm, op_set, op_bist;
  logic [15:0] addr, last;
  logic [12:0] cnt;
  logic [3:0]  phase;
  logic        go;
  logic [15:0] first;
  logic [15:0] range_end;
  logic        want_pgm, want_set, want_bist;
  logic [12:0] pulse_len, gap_len;
  logic [7:0]  b_rdata;
  logic        b_we;
  logic        byte_done;
  logic        byte_bad;

  // Queued operations start only from idle, so busy never overlaps
  assign go = state == OTPC_IDLE && (pgm_trig || load_trig || pu_pending);
  assign range_end = mode[`OTPC_BIT_MANUAL] ? mend : AUTO_LAST;

  always_comb begin
    want_pgm  = pgm_trig;
    want_set  = 1'b0;
    want_bist = 1'b0;
    if (!pgm_trig && load_trig) begin
      want_set  = extra[`OTPC_BIT_WR_SET];
      want_bist = extra[`OTPC_BIT_BIST_EN];
    end else if (!pgm_trig && pu_pending) begin
      want_set = !extra[`OTPC_BIT_PU_DATA] && extra[`OTPC_BIT_PU_SET];
    end
    first = mode[`OTPC_BIT_MANUAL] ? mstart : AUTO_FIRST;
    // A start past the range end would wrap round the whole address space
    if (want_set && sstart >= first && sstart <= range_end)
      first = sstart;
  end

  // Ten-bit program pulse in steps of eight clocks
  assign pulse_len = op_pgm ?
    13'({load_pulse[7:6], pgm_pulse} * `OTPC_PULSE_STEP)
    : {7'h00, load_pulse[5:0]};
  assign gap_len = op_pgm ? 13'(pgm_gap * `OTPC_GAP_STEP)
                          : 13'(load_gap * `OTPC_GAP_STEP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= OTPC_IDLE;
      op_pgm  <= 1'b0;
      op_set  <= 1'b0;
      op_bist <= 1'b0;
      addr    <= 16'h0000;
      last    <= 16'h0000;
      cnt     <= 13'h0000;
      phase   <= 4'h0;
    end else begin
      case (state)
        OTPC_IDLE: begin
          if (go) begin
            op_pgm  <= want_pgm;
            op_set  <= want_set;
            op_bist <= want_bist;
            addr    <= first;
            last    <= range_end;
            phase   <= 4'h0;
            cnt     <= {9'h000, timing_b[3:0]};
            state   <= OTPC_SETUP;
          end
        end
        OTPC_SETUP: begin
          // Gate start, then power select, then chip select
          if (cnt == 13'h0000) begin
            if (phase == 4'h0) begin
              phase <= 4'h1;
              cnt   <= {9'h000, timing_a[3:0]};
            end else begin
              cnt   <= (pulse_len == 13'h0000) ? 13'h0001 : pulse_len;
              state <= OTPC_STROBE;
            end
          end else begin
            cnt <= cnt - 13'h0001;
          end
        end
        OTPC_STROBE: begin
          if (cnt <= 13'h0001) begin
            cnt   <= gap_len;
            state <= (addr == last) ? OTPC_FINISH : OTPC_GAP;
            // Step early so the buffer byte is ready at the next strobe
            if (addr != last)
              addr <= addr + 16'h0001;
          end else begin
            cnt <= cnt - 13'h0001;
          end
        end
        OTPC_GAP: begin
          if (cnt == 13'h0000) begin
            cnt   <= (pulse_len == 13'h0000) ? 13'h0001 : pulse_len;
            state <= OTPC_STROBE;
          end else begin
            cnt <= cnt - 13'h0001;
          end
        end
        OTPC_FINISH: begin
          // Hold chip select, then drop power select
          if (cnt == 13'h0000 || phase == 4'h1) begin
            phase <= 4'h2;
            cnt   <= {9'h000, timing_b[7:4]};
            if (phase == 4'h2 && cnt == 13'h0000)
              state <= OTPC_IDLE;
          end else begin
            cnt <= cnt - 13'h0001;
          end
          if (phase == 4'h2 && cnt != 13'h0000)
            cnt <= cnt - 13'h0001;
        end
        default: state <= OTPC_IDLE;
      endcase
    end
  end

  // Byte finished at the last strobe cycle
  assign byte_done = state == OTPC_STROBE && cnt <= 13'h0001;
  assign b_we      = byte_done && !op_pgm && !op_set && !op_bist;
  assign byte_bad  = op_bist && macro_rdata !=
                     (extra[`OTPC_BIT_BIST_ZERO] ? 8'h00 : b_rdata);

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_w     <= 1'b0;
      busy_r     <= 1'b0;
      pu_pending <= 1'b1;
    end else begin
      if (go && want_pgm)
        busy_w <= 1'b1;
      else if (state == OTPC_FINISH && op_pgm && phase == 4'h2
               && cnt == 13'h0000)
        busy_w <= 1'b0;
      if (go && !want_pgm)
        busy_r <= 1'b1;
      else if (state == OTPC_FINISH && !op_pgm && phase == 4'h2
               && cnt == 13'h0000)
        busy_r <= 1'b0;
      // Power-up runs one settings pass when pu_set is set and pu_data clear, otherwise a data pass
      if (go && !pgm_trig && !load_trig && pu_pending)
        pu_pending <= !want_set && extra[`OTPC_BIT_PU_SET];
      else if (pu_pending && state == OTPC_IDLE
               && !extra[`OTPC_BIT_PU_DATA] && !extra[`OTPC_BIT_PU_SET])
        pu_pending <= 1'b0;
    end
  end

  // Self-test outcome; first mismatch is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bist_done <= 1'b0;
      bist_err  <= 1'b0;
      fail_addr <= 16'h0000;
    end else begin
      if (go && want_bist) begin
        bist_done <= 1'b0;
        bist_err  <= 1'b0;
      end else if (byte_done && byte_bad && !bist_err) begin
        bist_err  <= 1'b1;
        fail_addr <= addr;
      end
      if (state == OTPC_FINISH && op_bist && phase == 4'h2
          && cnt == 13'h0000)
        bist_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Byte buffer
  // ----------------------------------------------------------------------
  logic [7:0] a_rdata;

  otpc_buffer #(
    .ADDR_W (BUF_AW),
    .DEPTH  (8192)
  ) u_buf (
    .hclk    (hclk),
    .a_we    (wr_en && is_buf),
    .a_addr  (req.index[BUF_AW-1:0]),
    .a_wdata (wbyte),
    .a_rdata (a_rdata),
    .b_we    (b_we),
    .b_addr  (addr[BUF_AW-1:0]),
    .b_wdata (macro_rdata),
    .b_rdata (b_rdata)
  );

  // ----------------------------------------------------------------------
  // Read answer: one wait state, two for the buffer's registered output
  // ----------------------------------------------------------------------
  logic [7:0] rbyte;

  always_comb begin
    case (req.index)
      `OTPC_IDX_PGM_CTRL:   rbyte = {busy_w, 7'h00};
      `OTPC_IDX_LOAD_CTRL:  rbyte = {busy_r, 1'b0, bist_err, bist_done,
                                     4'h0};
      `OTPC_IDX_PGM_PULSE:  rbyte = pgm_pulse;
      `OTPC_IDX_LOAD_PULSE: rbyte = load_pulse;
      `OTPC_IDX_MODE:       rbyte = mode;
      `OTPC_IDX_EXTRA:      rbyte = extra;
      `OTPC_IDX_BUF_TEST:   rbyte = buf_test;
      `OTPC_IDX_TIMING_A:   rbyte = timing_a;
      `OTPC_IDX_MSTART_H:   rbyte = mstart[15:8];
      `OTPC_IDX_MSTART_L:   rbyte = mstart[7:0];
      `OTPC_IDX_MEND_H:     rbyte = mend[15:8];
      `OTPC_IDX_MEND_L:     rbyte = mend[7:0];
      `OTPC_IDX_SSTART_H:   rbyte = sstart[15:8];
      `OTPC_IDX_SSTART_L:   rbyte = sstart[7:0];
      `OTPC_IDX_FAIL_H:     rbyte = fail_addr[15:8];
      `OTPC_IDX_FAIL_L:     rbyte = fail_addr[7:0];
      `OTPC_IDX_PGM_GAP:    rbyte = pgm_gap;
      `OTPC_IDX_LOAD_GAP:   rbyte = load_gap;
      `OTPC_IDX_TIMING_B:   rbyte = timing_b;
      default:              rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      rd_wait   <= 1'b0;
      rd_late   <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        hreadyout <= 1'b0;
        rd_wait   <= 1'b1;
      end else if (rd_wait && is_buf && !rd_late) begin
        rd_late   <= 1'b1;
      end else if (rd_wait) begin
        hreadyout <= 1'b1;
        rd_wait   <= 1'b0;
        rd_late   <= 1'b0;
        hrdata    <= {24'h000000, is_buf ? a_rdata : rbyte};
      end else begin
        hreadyout <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Macro pins and setting output, all registered
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      macro         <= '0;
      setting_valid <= 1'b0;
      setting_data  <= 8'h00;
    end else begin
      macro.program_gate_start   <= state != OTPC_IDLE && op_pgm;
      macro.power_select         <= state != OTPC_IDLE
                                    && !(state == OTPC_SETUP
                                         && phase == 4'h0);
      macro.chip_select_low      <= !(state == OTPC_STROBE
                                      || state == OTPC_GAP
                                      || (state == OTPC_FINISH
                                          && phase != 4'h2));
      macro.program_gate_end_low <= !(op_pgm && state == OTPC_STROBE);
      macro.strobe               <= state == OTPC_STROBE;
      macro.write                <= op_pgm;
      macro.addr                 <= addr;
      macro.wdata                <= b_rdata;
      setting_valid              <= byte_done && op_set;
      setting_data               <= macro_rdata;
    end
  end

endmodule

// ===== tb/otpc_otp_model.sv
// Behavioural model of the one-time memory array behind the macro pins
// Assumes strobe is a level across each pulse, as the controller drives
`timescale 1ns/100ps
module otpc_otp_model
  import otpc_pkg::*;
(
  input  wire logic           hclk,  // System clock
  input  wire otpc_macro_type macro, // Controls from the controller
  output logic [7:0]          rdata  // Byte back to the controller
);
  logic [7:0] mem [logic [15:0]];
  logic [7:0] wq  [$];
  logic [7:0] last;
  logic       stb_d;
  function automatic logic [7:0] get(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction
  initial begin
    last = 8'h00;
    stb_d = 1'b0;
  end
  // Fuses only ever go from 0 to 1, so a second program cannot clear
  always @(posedge hclk) begin
    stb_d <= macro.strobe;
    if (macro.strobe && !stb_d && macro.write) begin
      mem[macro.addr] = get(macro.addr) | macro.wdata;
      wq.push_back(macro.wdata);
    end
    if (macro.strobe && !macro.write)
      last <= get(macro.addr);
  end
  // Outside a read pulse the line shows no stale byte
  always @* begin
    if (macro.strobe && !macro.write)
      rdata = get(macro.addr);
    else
      rdata = ~last;
  end
endmodule

// ===== tb/otpc_monitor.sv
// Port checks for the controller: bus answers and strobe stability
// Assumes binding onto otpc_top, seeing its ports only
`timescale 1ns/100ps
`include "otpc_map.svh"
module otpc_monitor
  import otpc_pkg::*;
(
  input wire logic           hclk,          // System clock
  input wire logic           hresetn,       // Reset, active low
  input wire logic           hsel,          // Slave select
  input wire logic [31:0]    haddr,         // Byte address
  input wire logic [1:0]     htrans,        // Transfer type
  input wire logic           hwrite,        // Write when high
  input wire logic           hready,        // Bus ready
  input wire logic [31:0]    hrdata,        // Read data
  input wire logic           hreadyout,     // Slave ready
  input wire logic           hresp,         // Response
  input wire otpc_macro_type macro,         // Macro controls
  input wire logic           setting_valid  // Setting byte strobe
);
  logic rq, rq_buf;
  assign rq     = hsel && htrans[1] && hready;
  assign rq_buf = rq && !hwrite && haddr[17:2] >= `OTPC_IDX_BUF_BASE;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  read_wait_a: assert property (rq && !hwrite && !rq_buf |=>
    !hreadyout ##1 hreadyout) else $error("read answer timing wrong");
  read_buf_a: assert property (rq_buf |=>
    !hreadyout [*2] ##1 hreadyout) else $error("buffer read timing wrong");
  write_fast_a: assert property (rq && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_short_a: assert property (!hreadyout [*2] |=> hreadyout)
    else $error("wait state too long");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  rdata_byte_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  strobe_addr_a: assert property (macro.strobe && $past(macro.strobe) |-> $stable(macro.addr))
    else $error("address moved in strobe");
  strobe_data_a: assert property (macro.strobe && macro.write && $past(macro.strobe) |-> $stable(macro.wdata))
    else $error("write byte moved in strobe");
  cover property (rq && !hwrite);
  cover property (macro.strobe && macro.write);
  cover property (setting_valid);
endmodule
bind otpc_top otpc_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .macro(macro), .haddr(haddr),
  .setting_valid(setting_valid));

// ===== tb/otpc_tb_top.sv
// Self-checking bench: registers, program, load, self test, settings
// Assumes the memory model on the macro pins and a short auto range
`timescale 1ns/100ps
module otpc_tb_top
  import otpc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [7:0] mrd, sd, rd, sfirst;
  logic [7:0] d [8];
  otpc_macro_type macro;
  int err_count, checked, cyc, nset, i;
  localparam logic [15:0] RI [9] = '{16'h3D82, 16'h3D83, 16'h3D84,
    16'h3D85, 16'h3D86, 16'h3D87, 16'h3D90, 16'h3D91, 16'h3D92};
  localparam logic [7:0] RV [9] = '{8'h2E, 8'h12, 8'h80, 8'h13, 8'h01,
    8'h6C, 8'h18, 8'h06, 8'h2A};
  otpc_top #(.AUTO_FIRST(16'h7000), .AUTO_LAST(16'h7007)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .macro(macro), .macro_rdata(mrd),
    .setting_valid(sv), .setting_data(sd));
  otpc_otp_model m (.hclk(hclk), .macro(macro), .rdata(mrd));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic results();
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [7:0] wd, output logic [7:0] r);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {14'h0, a, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    xfer(1'b1, a, v, rd);
  endtask
  task automatic rc(input string n, input logic [15:0] a,
                    input logic [7:0] e, mk);
    xfer(1'b0, a, 8'h00, rd);
    chk(n, e & mk, rd & mk);
  endtask
  // Polls a busy flag; the cycle ceiling ends a hang
  task automatic wt(input logic [15:0] a);
    rd = 8'h80;
    while (rd[7] !== 1'b0) xfer(1'b0, a, 8'h00, rd);
  endtask
  task automatic go(input logic [7:0] x);
    wr(16'h3D85, x); wr(16'h3D81, 8'h01); wt(16'h3D81);
  endtask
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (sv === 1'b1) begin
      if (nset == 0) sfirst <= sd;
      nset <= nset + 1;
    end
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end
  initial begin
    {hresetn, hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'b010; rnd = 32'hF15E; cyc = 0; nset = 0;
    err_count = 0; checked = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rc("load busy", 16'h3D81, 8'h80, 8'h80);
    for (i = 0; i < 9; i++) rc("reset", RI[i], RV[i], 8'hFF);
    for (i = 0; i < 6; i++) rc("addr reset", 16'h3D88 + i, 8'h00, 8'hFF);
    wt(16'h3D81);
    chk("pwr settings", 8'h01, {7'h0, nset != 0});
    for (i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      wr(16'h3D88 + i % 6, rnd[7:0]);
      rc("rw", 16'h3D88 + i % 6, rnd[7:0], 8'hFF);
    end
    wr(16'h3D93, 8'hAA); rc("unmapped", 16'h3D93, 8'h00, 8'hFF);
    wr(16'h3D82, 8'h03); wr(16'h3D83, 8'h04);
    wr(16'h3D90, 8'h01); wr(16'h3D91, 8'h02);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd); d[i] = rnd[7:0] | 8'h01; wr(16'h7000 + i, d[i]);
    end
    wr(16'h3D84, 8'h00); wr(16'h3D80, 8'h01);
    rc("pgm busy", 16'h3D80, 8'h80, 8'h80); wt(16'h3D80);
    for (i = 0; i < 8; i++) chk("programmed", d[i], m.wq[i]);
    wr(16'h3D84, 8'h80); wr(16'h3D80, 8'h01);
    rc("pgm blocked", 16'h3D80, 8'h00, 8'h80);
    chk("no writes", 8'h08, 8'(m.wq.size()));
    for (i = 0; i < 8; i++) wr(16'h7000 + i, 8'h00);
    wr(16'h3D84, 8'h40); wr(16'h3D88, 8'h70); wr(16'h3D89, 8'h02);
    wr(16'h3D8A, 8'h70); wr(16'h3D8B, 8'h05); go(8'h00);
    for (i = 0; i < 8; i++) rc("loaded", 16'h7000 + i, (i > 1 && i < 6) ? d[i] : 8'h00, 8'hFF);
    go(8'h10); rc("bist pass", 16'h3D81, 8'h10, 8'h30);
    go(8'h30); rc("bist fail", 16'h3D81, 8'h30, 8'h30);
    wr(16'h3D8E, 8'hFF); rc("fail hi", 16'h3D8E, 8'h70, 8'hFF);
    rc("fail lo", 16'h3D8F, 8'h02, 8'hFF);
    nset = 0; wr(16'h3D8C, 8'h70); wr(16'h3D8D, 8'h04); go(8'h01);
    chk("setting byte", d[4], sfirst);
    results();
  end
endmodule
